// *** bcr_pkg.sv ***
// Constants, types and layout of the third buck register bank
package bcr_pkg;

    // Register addresses
    localparam logic [7:0] BCR_ADDR_RUN_VOLT  = 8'h3e;
    localparam logic [7:0] BCR_ADDR_STBY_VOLT = 8'h3f;
    localparam logic [7:0] BCR_ADDR_SLP_VOLT  = 8'h40;
    localparam logic [7:0] BCR_ADDR_CTRL      = 8'h41;

    // Control register bit positions
    localparam int BCR_BIT_RUN_EN  = 0;
    localparam int BCR_BIT_STBY_EN = 1;
    localparam int BCR_BIT_SLP_EN  = 2;
    localparam int BCR_BIT_LPWR    = 3;
    localparam int BCR_BIT_FPWM    = 6;
    localparam int BCR_BIT_RDIS    = 7;

    // Reset values and masks
    localparam logic [7:0] BCR_CTRL_RESET = 8'h00;
    localparam logic [7:0] BCR_CTRL_MASK  = 8'hcf;
    localparam logic [3:0] BCR_VOLT_RESET = 4'h0;

    // I2C framing
    localparam logic [3:0] BCR_BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] BCR_DEF_SLAVE_ADDR = 7'h2a; // Arbitrary value

    // Power mode codes from the sequencer
    localparam logic [1:0] BCR_MODE_RUN     = 2'h0;
    localparam logic [1:0] BCR_MODE_STANDBY = 2'h1;
    localparam logic [1:0] BCR_MODE_SLEEP   = 2'h2;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } bcr_wr_t;

    typedef struct packed {
        logic [3:0] run_code;
        logic [3:0] standby_code;
        logic [3:0] sleep_code;
        logic       run_enable;
        logic       standby_enable;
        logic       discharge_disable;
    } bcr_fuse_t;

    typedef struct packed {
        logic       buck_on;
        logic       low_power;
        logic       forced_pwm;
        logic       discharge_on;
        logic [3:0] voltage_code;
    } bcr_drive_t;

    typedef enum logic [2:0] {
        BCR_IDLE,
        BCR_ADDR,
        BCR_ADDR_ACK,
        BCR_WR_BYTE,
        BCR_WR_ACK,
        BCR_RD_BYTE,
        BCR_RD_ACK
    } bcr_state_t;

endpackage

// *** bcr_reg_bank.sv ***
// Register bank and converter drive for the third buck
`timescale 1ns/10ps
`default_nettype none
module bcr_reg_bank (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // Fuse defaults
    input  wire bcr_pkg::bcr_fuse_t fuse,
    // Host access
    input  wire bcr_pkg::bcr_wr_t   wr,
    input  wire logic [7:0]    rd_addr,
    output logic [7:0]         rd_data,
    // Converter side
    input  wire logic [1:0]    power_mode,
    output bcr_pkg::bcr_drive_t drive
);
    import bcr_pkg::*;

    logic       load_pending_r;
    logic [3:0] run_code_r;
    logic [3:0] stby_code_r;
    logic [3:0] slp_code_r;
    logic [7:0] ctrl_r;
    logic       on_nxt;
    logic [3:0] code_nxt;

    // Fuses are sampled one edge after release, never under reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_pending_r <= 1'b1;
        end else begin
            load_pending_r <= 1'b0;
        end
    end

    // Voltage codes: only the fuse load writes them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_code_r  <= BCR_VOLT_RESET;
            stby_code_r <= BCR_VOLT_RESET;
            slp_code_r  <= BCR_VOLT_RESET;
        end else if (load_pending_r) begin
            run_code_r  <= fuse.run_code;
            stby_code_r <= fuse.standby_code;
            slp_code_r  <= fuse.sleep_code;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= BCR_CTRL_RESET;
        end else if (load_pending_r) begin
            ctrl_r <= BCR_CTRL_RESET;
            ctrl_r[BCR_BIT_RUN_EN]  <= fuse.run_enable;
            ctrl_r[BCR_BIT_STBY_EN] <= fuse.standby_enable;
            ctrl_r[BCR_BIT_RDIS]    <= fuse.discharge_disable;
        end else if (wr.en && wr.addr == BCR_ADDR_CTRL) begin
            ctrl_r <= wr.data & BCR_CTRL_MASK;
        end
    end

    always_comb begin
        if (rd_addr == BCR_ADDR_RUN_VOLT) begin
            rd_data = {4'h0, run_code_r};
        end else if (rd_addr == BCR_ADDR_STBY_VOLT) begin
            rd_data = {4'h0, stby_code_r};
        end else if (rd_addr == BCR_ADDR_SLP_VOLT) begin
            rd_data = {4'h0, slp_code_r};
        end else if (rd_addr == BCR_ADDR_CTRL) begin
            rd_data = ctrl_r;
        end else begin
            rd_data = 8'h00;
        end
    end

    always_comb begin
        case (power_mode)
            BCR_MODE_STANDBY: begin
                on_nxt   = ctrl_r[BCR_BIT_STBY_EN];
                code_nxt = stby_code_r;
            end
            BCR_MODE_SLEEP: begin
                on_nxt   = ctrl_r[BCR_BIT_SLP_EN];
                code_nxt = slp_code_r;
            end
            default: begin
                on_nxt   = ctrl_r[BCR_BIT_RUN_EN];
                code_nxt = run_code_r;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive <= '0;
        end else begin
            drive.buck_on      <= on_nxt;
            // Mode 3 counts as Run, so only Standby and Sleep qualify
            drive.low_power    <= on_nxt && ctrl_r[BCR_BIT_LPWR]
                                  && (power_mode == BCR_MODE_STANDBY
                                      || power_mode == BCR_MODE_SLEEP);
            drive.forced_pwm   <= ctrl_r[BCR_BIT_FPWM];
            drive.discharge_on <= !on_nxt && !ctrl_r[BCR_BIT_RDIS];
            drive.voltage_code <= code_nxt;
        end
    end

endmodule // bcr_reg_bank
`default_nettype wire

// *** bcr_i2c_regs.sv ***
// I2C target giving host access to the third buck register bank
`timescale 1ns/10ps
`default_nettype none
module bcr_i2c_regs #(
    parameter logic [6:0] SLAVE_ADDR = bcr_pkg::BCR_DEF_SLAVE_ADDR
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    // I2C pins
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    // Fuse defaults
    input  wire logic [3:0]  FUSE_RUN_CODE,
    input  wire logic [3:0]  FUSE_STANDBY_CODE,
    input  wire logic [3:0]  FUSE_SLEEP_CODE,
    input  wire logic        FUSE_RUN_ENABLE,
    input  wire logic        FUSE_STANDBY_ENABLE,
    input  wire logic        FUSE_DISCHARGE_DISABLE,
    // Sequencer power mode
    input  wire logic [1:0]  POWER_MODE,
    // Converter controls
    output logic             BUCK_ON,
    output logic             BUCK_LOW_POWER,
    output logic             BUCK_FORCED_PWM,
    output logic             BUCK_DISCHARGE_ON,
    output logic [3:0]       BUCK_VOLTAGE_CODE
);
    import bcr_pkg::*;

    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic       scl_prev_r;
    logic       sda_prev_r;
    logic       scl_s;
    logic       sda_s;
    logic       start_det;
    logic       stop_det;
    logic       scl_rise;
    logic       scl_fall;

    bcr_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic       ptr_phase_r;
    logic       read_r;
    logic       nack_r;
    logic       sda_oe_r;
    bcr_wr_t    wr_r;
    logic [7:0] rd_data;
    bcr_fuse_t  fuse;
    bcr_drive_t drive;

    function automatic logic byte_full(input logic [3:0] cnt);
        byte_full = (cnt == BCR_BITS_PER_BYTE);
    endfunction

    // Pins are asynchronous to CORE_CLK
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], SCL_I};
            sda_sync_r <= {sda_sync_r[0], SDA_I};
            scl_prev_r <= scl_sync_r[1];
            sda_prev_r <= sda_sync_r[1];
        end
    end

    assign scl_s     = scl_sync_r[1];
    assign sda_s     = sda_sync_r[1];
    assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    assign stop_det  = scl_s && scl_prev_r && !sda_prev_r && sda_s;
    assign scl_rise  = scl_s && !scl_prev_r;
    assign scl_fall  = !scl_s && scl_prev_r;

    // Protocol engine; SDA only changes after SCL falls
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r     <= BCR_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            tx_r        <= 8'h00;
            ptr_r       <= 8'h00;
            ptr_phase_r <= 1'b0;
            read_r      <= 1'b0;
            nack_r      <= 1'b0;
            sda_oe_r    <= 1'b0;
            wr_r        <= '0;
        end else begin
            wr_r.en <= 1'b0;
            if (stop_det) begin
                state_r  <= BCR_IDLE;
                sda_oe_r <= 1'b0;
            end else if (start_det) begin
                state_r     <= BCR_ADDR;
                bit_cnt_r   <= 4'h0;
                ptr_phase_r <= 1'b1;
                sda_oe_r    <= 1'b0;
            end else if (scl_rise) begin
                case (state_r)
                    BCR_ADDR, BCR_WR_BYTE: begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    BCR_RD_BYTE: begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    BCR_RD_ACK: begin
                        nack_r <= sda_s;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    BCR_ADDR: begin
                        if (byte_full(bit_cnt_r)) begin
                            if (shift_r[7:1] == SLAVE_ADDR) begin
                                read_r   <= shift_r[0];
                                sda_oe_r <= 1'b1;
                                state_r  <= BCR_ADDR_ACK;
                            end else begin
                                state_r <= BCR_IDLE;
                            end
                        end
                    end
                    BCR_ADDR_ACK: begin
                        bit_cnt_r <= 4'h0;
                        if (read_r) begin
                            tx_r     <= rd_data;
                            sda_oe_r <= !rd_data[7];
                            ptr_r    <= ptr_r + 8'h01;
                            state_r  <= BCR_RD_BYTE;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r  <= BCR_WR_BYTE;
                        end
                    end
                    BCR_WR_BYTE: begin
                        if (byte_full(bit_cnt_r)) begin
                            sda_oe_r <= 1'b1;
                            state_r  <= BCR_WR_ACK;
                            if (ptr_phase_r) begin
                                ptr_r       <= shift_r;
                                ptr_phase_r <= 1'b0;
                            end else begin
                                // Bank drops read-only and unmapped writes
                                wr_r.en   <= 1'b1;
                                wr_r.addr <= ptr_r;
                                wr_r.data <= shift_r;
                                ptr_r     <= ptr_r + 8'h01;
                            end
                        end
                    end
                    BCR_WR_ACK: begin
                        sda_oe_r  <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        state_r   <= BCR_WR_BYTE;
                    end
                    BCR_RD_BYTE: begin
                        if (byte_full(bit_cnt_r)) begin
                            sda_oe_r <= 1'b0;
                            state_r  <= BCR_RD_ACK;
                        end else begin
                            tx_r     <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= !tx_r[6];
                        end
                    end
                    BCR_RD_ACK: begin
                        bit_cnt_r <= 4'h0;
                        if (nack_r) begin
                            // Host ended the read; wait for stop or restart
                            state_r <= BCR_IDLE;
                        end else begin
                            tx_r     <= rd_data;
                            sda_oe_r <= !rd_data[7];
                            ptr_r    <= ptr_r + 8'h01;
                            state_r  <= BCR_RD_BYTE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign SDA_O  = 1'b0;
    assign SDA_OE = sda_oe_r;

    assign fuse.run_code          = FUSE_RUN_CODE;
    assign fuse.standby_code      = FUSE_STANDBY_CODE;
    assign fuse.sleep_code        = FUSE_SLEEP_CODE;
    assign fuse.run_enable        = FUSE_RUN_ENABLE;
    assign fuse.standby_enable    = FUSE_STANDBY_ENABLE;
    assign fuse.discharge_disable = FUSE_DISCHARGE_DISABLE;

    bcr_reg_bank u_bank (
        .clk        (CORE_CLK),
        .resetn     (RESETN),
        .fuse       (fuse),
        .wr         (wr_r),
        .rd_addr    (ptr_r),
        .rd_data    (rd_data),
        .power_mode (POWER_MODE),
        .drive      (drive)
    );

    assign BUCK_ON           = drive.buck_on;
    assign BUCK_LOW_POWER    = drive.low_power;
    assign BUCK_FORCED_PWM   = drive.forced_pwm;
    assign BUCK_DISCHARGE_ON = drive.discharge_on;
    assign BUCK_VOLTAGE_CODE = drive.voltage_code;

endmodule // bcr_i2c_regs
`default_nettype wire

// *** bcr_i2c_regs_assertions.sv ***
// Checker of converter drive relations at the register bank pins
`timescale 1ns/10ps
`default_nettype none
module bcr_i2c_regs_assertions
    import bcr_pkg::*;
(
    // Clock, reset and bus pins
    input wire logic       CORE_CLK, RESETN, SCL_I, SDA_O, SDA_OE,
    // Fuses and mode
    input wire logic [3:0] FUSE_RUN_CODE, FUSE_STANDBY_CODE, FUSE_SLEEP_CODE,
    input wire logic       FUSE_RUN_ENABLE, FUSE_STANDBY_ENABLE, FUSE_DISCHARGE_DISABLE,
    input wire logic [1:0] POWER_MODE,
    // Converter controls
    input wire logic       BUCK_ON, BUCK_LOW_POWER, BUCK_FORCED_PWM, BUCK_DISCHARGE_ON,
    input wire logic [3:0] BUCK_VOLTAGE_CODE
);
    logic [1:0] cnt_r;
    logic       ready;
    logic       is_run;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) cnt_r <= 2'h0;
        else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
    end
    // Drive shows fuse values only from the second edge after release
    assign ready = cnt_r[1];
    // Mode 3 is served as Run
    assign is_run = (POWER_MODE == BCR_MODE_RUN) || (POWER_MODE == 2'h3);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    property p_run_code;
        ready && $past(is_run) |-> BUCK_VOLTAGE_CODE == FUSE_RUN_CODE;
    endproperty
    a_run_code: assert property (p_run_code) else $error("run code differs");
    property p_stby_code;
        ready && $past(POWER_MODE) == BCR_MODE_STANDBY |-> BUCK_VOLTAGE_CODE == FUSE_STANDBY_CODE;
    endproperty
    a_stby_code: assert property (p_stby_code) else $error("standby code differs");
    property p_slp_code;
        ready && $past(POWER_MODE) == BCR_MODE_SLEEP |-> BUCK_VOLTAGE_CODE == FUSE_SLEEP_CODE;
    endproperty
    a_slp_code: assert property (p_slp_code) else $error("sleep code differs");
    property p_fuse_on;
        cnt_r == 2'h2 |-> BUCK_ON == ($past(POWER_MODE) == BCR_MODE_STANDBY ? FUSE_STANDBY_ENABLE :
            $past(POWER_MODE) == BCR_MODE_SLEEP ? 1'b0 : FUSE_RUN_ENABLE);
    endproperty
    a_fuse_on: assert property (p_fuse_on) else $error("enable default wrong");
    property p_fuse_rest;
        cnt_r == 2'h2 |-> !BUCK_FORCED_PWM && !BUCK_LOW_POWER
            && BUCK_DISCHARGE_ON == (!BUCK_ON && !FUSE_DISCHARGE_DISABLE);
    endproperty
    a_fuse_rest: assert property (p_fuse_rest) else $error("control default wrong");
    property p_dis_off;
        BUCK_DISCHARGE_ON |-> !BUCK_ON;
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("discharge while on");
    property p_lp_mode;
        BUCK_LOW_POWER |-> BUCK_ON && !$past(is_run);
    endproperty
    a_lp_mode: assert property (p_lp_mode) else $error("low power outside standby or sleep");
    property p_sda_low;
        SDA_O == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin not open drain");
    // Answer bits move only in the low half of SCL
    property p_sda_quiet;
        SCL_I [*4] |-> $stable(SDA_OE);
    endproperty
    a_sda_quiet: assert property (p_sda_quiet) else $error("data moved while clock high");
    c_lp: cover property (ready && BUCK_LOW_POWER);
    c_dis: cover property (ready && BUCK_DISCHARGE_ON);
    c_ack: cover property (SDA_OE);
    c_slp_on: cover property (ready && $past(POWER_MODE) == BCR_MODE_SLEEP && BUCK_ON);
endmodule // bcr_i2c_regs_assertions
bind bcr_i2c_regs bcr_i2c_regs_assertions u_bcr_i2c_regs_assertions (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
    .FUSE_RUN_CODE(FUSE_RUN_CODE), .FUSE_STANDBY_CODE(FUSE_STANDBY_CODE),
    .FUSE_SLEEP_CODE(FUSE_SLEEP_CODE), .FUSE_RUN_ENABLE(FUSE_RUN_ENABLE),
    .FUSE_STANDBY_ENABLE(FUSE_STANDBY_ENABLE), .FUSE_DISCHARGE_DISABLE(FUSE_DISCHARGE_DISABLE),
    .POWER_MODE(POWER_MODE), .BUCK_ON(BUCK_ON), .BUCK_LOW_POWER(BUCK_LOW_POWER),
    .BUCK_FORCED_PWM(BUCK_FORCED_PWM), .BUCK_DISCHARGE_ON(BUCK_DISCHARGE_ON),
    .BUCK_VOLTAGE_CODE(BUCK_VOLTAGE_CODE));
`default_nettype wire

// *** bcr_i2c_host.sv ***
// Host model driving the I2C control interface
`timescale 1ns/10ps
`default_nettype none
module bcr_i2c_host (
    // Clock and bus
    input  wire logic clk,
    input  wire logic sda_in,
    output var logic  scl,
    output var logic  sda_drv
);
    // Half SCL period, twice the four-clock minimum
    localparam int H = 8;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data moves two clocks after SCL falls to keep hold time
    task automatic bit_io(input logic b, output logic q);
        hw(2);
        sda_drv = b;
        hw(H - 2);
        scl = 1'b1;
        hw(H / 2);
        q = sda_in;
        hw(H / 2);
        scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] b, input logic ackb,
                           output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(b[i], q[i]);
        bit_io(ackb, ak);
    endtask
    // Also serves as repeated start from SCL low
    task automatic start();
        hw(2);
        sda_drv = 1'b1;
        hw(H);
        scl = 1'b1;
        hw(H);
        sda_drv = 1'b0;
        hw(H);
        scl = 1'b0;
    endtask
    task automatic stop();
        hw(2);
        sda_drv = 1'b0;
        hw(H);
        scl = 1'b1;
        hw(H);
        sda_drv = 1'b1;
        hw(H);
    endtask
endmodule // bcr_i2c_host
`default_nettype wire

// *** buck3_control_registers_bench.sv ***
// Self-checking bench of the third buck register bank
`timescale 1ns/10ps
`default_nettype none
module buck3_control_registers_bench;
    import bcr_pkg::*;
    logic       core_clk, resetn, scl, sda_drv, sda_oe, sda_o;
    logic [3:0] f_run, f_stby, f_slp, code;
    logic       f_ren, f_sen, f_dis, on, lp, fp, dis;
    logic [1:0] mode;
    logic [23:0] d;
    int         err_total, tests_run, cyc;
    // Pull-up on the data wire
    wire        sda = sda_drv & ~sda_oe;
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    bcr_i2c_regs u_bcr_i2c_regs (
        .CORE_CLK(core_clk), .RESETN(resetn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .FUSE_RUN_CODE(f_run), .FUSE_STANDBY_CODE(f_stby),
        .FUSE_SLEEP_CODE(f_slp), .FUSE_RUN_ENABLE(f_ren), .FUSE_STANDBY_ENABLE(f_sen),
        .FUSE_DISCHARGE_DISABLE(f_dis), .POWER_MODE(mode), .BUCK_ON(on), .BUCK_LOW_POWER(lp),
        .BUCK_FORCED_PWM(fp), .BUCK_DISCHARGE_ON(dis), .BUCK_VOLTAGE_CODE(code));
    bcr_i2c_host u_bcr_i2c_host (.clk(core_clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
    task automatic final_report();
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic do_reset(input logic [14:0] f);
        @(negedge core_clk);
        resetn = 1'b0;
        {f_run, f_stby, f_slp, f_ren, f_sen, f_dis} = f;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
    task automatic addr(input logic rw);
        logic [7:0] q;
        logic       ak;
        u_bcr_i2c_host.start();
        u_bcr_i2c_host.byte_io({BCR_DEF_SLAVE_ADDR, rw}, 1'b1, q, ak);
        chk(ak, 1'b0, "address ack");
    endtask
    task automatic wr(input logic [7:0] p, input logic [23:0] v, input int n);
        logic [7:0] q;
        logic       ak;
        addr(1'b0);
        u_bcr_i2c_host.byte_io(p, 1'b1, q, ak);
        for (int i = n - 1; i >= 0; i--) u_bcr_i2c_host.byte_io(v[i*8+:8], 1'b1, q, ak);
        u_bcr_i2c_host.stop();
    endtask
    // Pointer auto-increments, last byte is refused to end the read
    task automatic rd(input logic [7:0] p, input int n, output logic [23:0] v);
        logic [7:0] q;
        logic       ak;
        v = 24'h0;
        addr(1'b0);
        u_bcr_i2c_host.byte_io(p, 1'b1, q, ak);
        addr(1'b1);
        for (int i = n - 1; i >= 0; i--) u_bcr_i2c_host.byte_io(8'hff, i == 0, v[i*8+:8], ak);
        u_bcr_i2c_host.stop();
    endtask
    task automatic t_fuse();
        do_reset({4'h5, 4'ha, 4'hf, 1'b1, 1'b1, 1'b0});
        rd(BCR_ADDR_RUN_VOLT, 3, d);
        chk(d, 24'h050a0f, "fuse codes");
        rd(BCR_ADDR_CTRL, 1, d);
        chk(d, 24'h03, "fuse ctrl");
    endtask
    task automatic t_readonly();
        wr(BCR_ADDR_RUN_VOLT, 24'hffffff, 3);
        rd(BCR_ADDR_RUN_VOLT, 3, d);
        chk(d, 24'h050a0f, "codes written");
        wr(8'h50, 24'ha5, 1);
        rd(8'h50, 1, d);
        chk(d, 24'h0, "unmapped");
    endtask
    // Each entry: control byte, power mode, then on, low power, forced PWM, discharge
    task automatic t_ctrl();
        logic [13:0] tb [9] = '{{8'hff, 2'h0, 4'ha}, {8'hff, 2'h1, 4'he}, {8'hff, 2'h2, 4'he},
            {8'h00, 2'h0, 4'h1}, {8'h80, 2'h1, 4'h0}, {8'h02, 2'h2, 4'h1},
            {8'h0a, 2'h1, 4'hc}, {8'h0b, 2'h3, 4'h8}, {8'h02, 2'h1, 4'h8}};
        logic [7:0]  c;
        logic [1:0]  m;
        logic [3:0]  e;
        for (int i = 0; i < 9; i++) begin
            {c, m, e} = tb[i];
            wr(BCR_ADDR_CTRL, {16'h0, c}, 1);
            mode = m;
            repeat (3) @(negedge core_clk);
            chk({on, lp, fp, dis}, e, "drive");
            chk(code, m == 2'h1 ? f_stby : m == 2'h2 ? f_slp : f_run, "code");
            rd(BCR_ADDR_CTRL, 1, d);
            chk(d, c & BCR_CTRL_MASK, "ctrl back");
        end
    endtask
    // Reset in mid-run reloads new fuses, unequal enables are accepted
    task automatic t_reset2();
        do_reset({4'h3, 4'h9, 4'h0, 1'b0, 1'b1, 1'b1});
        rd(BCR_ADDR_CTRL, 1, d);
        chk(d, 24'h82, "refuse ctrl");
        chk({on, lp, fp, dis, code}, {4'h8, 4'h9}, "refuse drive");
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        resetn = 1'b0;
        mode = BCR_MODE_RUN;
        {f_run, f_stby, f_slp, f_ren, f_sen, f_dis} = 15'h0;
        err_total = 0;
        tests_run = 0;
        cyc = 0;
        t_fuse();
        t_readonly();
        t_ctrl();
        t_reset2();
        final_report();
    end
endmodule // buck3_control_registers_bench
`default_nettype wire
